// [dcb_assertions.sv]
// checker for the data cache block ports
// ****
// port checks
// ****
module dcb_assertions (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire dcb_pkg::dcb_core_req_t core_req,
  input wire logic core_ready,
  input wire logic core_done,
  input wire logic tlb_fault,
  input wire logic core_abort,
  input wire logic flush_valid,
  input wire logic flush_user,
  input wire logic flush_ready,
  input wire logic undef_exc,
  input wire dcb_pkg::dcb_mem_req_t mem_req,
  input wire logic mem_ack
);
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // bus and core handshake timing
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not zero-wait okay");
  a_take_done: assert property (core_req.valid && core_ready |=> core_done)
    else $error("no done after take");
  a_done_cause: assert property (core_done |-> $past(core_req.valid && core_ready))
    else $error("done without take");
  // aborts for reserved space and faults
  a_resv_abort: assert property (core_req.valid && core_ready &&
    core_req.addr[31:28] == dcb_pkg::RESV_NIB |=> core_abort)
    else $error("reserved access not aborted");
  a_fault_abort: assert property (core_req.valid && core_ready &&
    tlb_fault |=> core_abort) else $error("fault not aborted");
  // memory side addressing and holding, undefined exception on user flush
  a_alias_bit: assert property (mem_req.valid &&
    mem_req.addr[31:30] == dcb_pkg::STATIC_TOP |-> !mem_req.addr[26])
    else $error("alias bit driven");
  a_mem_hold: assert property (mem_req.valid && !mem_ack |=> mem_req.valid
    && $stable(mem_req.addr) && $stable(mem_req.we))
    else $error("memory request dropped");
  a_undef_cause: assert property (undef_exc |->
    $past(flush_valid && flush_user && flush_ready))
    else $error("undefined without user flush");
endmodule

bind dcb_data_cache dcb_assertions u_chk (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .core_req(core_req), .core_ready(core_ready), .core_done(core_done),
  .tlb_fault(tlb_fault), .core_abort(core_abort),
  .flush_valid(flush_valid), .flush_user(flush_user),
  .flush_ready(flush_ready), .undef_exc(undef_exc), .mem_req(mem_req),
  .mem_ack(mem_ack)
);

// [dcb_data_cache.sv]
// data caches, write buffer, read buffer and control registers
module dcb_data_cache #(
  parameter int WB_DEPTH = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire dcb_pkg::dcb_core_req_t core_req,
  output logic core_ready,
  output logic core_done,
  output logic core_abort,
  output logic [31:0] core_rdata,
  input wire logic tlb_hit,
  input wire logic tlb_fault,
  input wire logic flush_valid,
  input wire logic flush_user,
  output logic flush_ready,
  output logic undef_exc,
  output dcb_pkg::dcb_mem_req_t mem_req,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic irq
);
  localparam int PW = $clog2(WB_DEPTH);
  localparam int CW = $clog2(WB_DEPTH + 1);

  // ****************************************
  // address helpers
  // ****************************************
  // static banks only see 26 address pins
  function automatic logic [31:0] phys(input logic [31:0] a);
    logic [31:0] r;
    r = a;
    if (a[31:30] == dcb_pkg::STATIC_TOP) begin
      r[dcb_pkg::ALIAS_BIT] = 1'b0;
    end
    return r;
  endfunction

  dcb_pkg::dcb_state_t st;
  logic [2:0] cnt;
  logic [31:0] pa;
  logic [2:0] set_i;
  logic [2:0] wrd;
  logic [23:0] tag;
  logic [23:0] m_tag [256];
  logic [31:0] m_dat [256][8];
  logic [255:0] m_val;
  logic [255:0] m_dty;
  logic [23:0] n_tag [16];
  logic [31:0] n_dat [16][8];
  logic [15:0] n_val;
  logic [15:0] n_dty;
  logic [4:0] rr [8];
  logic [7:0] lru;
  logic [26:0] pb_line [4];
  logic [7:0] pb_vld [4];
  logic [31:0] pb_dat [4][8];
  logic [26:0] wb_line [WB_DEPTH];
  logic [31:0] wb_dat [WB_DEPTH][8];
  logic [7:0] wb_msk [WB_DEPTH];
  logic [WB_DEPTH-1:0] wb_mrg;
  logic [PW-1:0] wb_hd;
  logic [PW-1:0] wb_tl;
  logic [PW-1:0] wb_tlp;
  logic [CW-1:0] wb_cnt;
  logic m_hit, n_hit, r_hit;
  logic [4:0] m_way;
  logic n_way;
  logic [1:0] r_ent;
  logic [1:0] ctrl;
  logic [2:0] stat;
  logic [2:0] mask;
  logic [31:0] pb_addr;
  logic pb_pend;
  logic [1:0] pb_e;
  logic [3:0] pb_left;
  logic unc_vld;
  logic [29:0] unc_addr;
  logic [31:0] unc_data;
  logic sync_pend;
  logic vmini;
  logic [7:0] vidx;
  logic [26:0] vline;
  logic [23:0] wtag;
  logic a_sel, a_we;
  logic [7:0] a_off;
  logic [31:0] pb_pa;

  assign pa = phys(core_req.addr);
  assign pb_pa = phys(pb_addr);
  assign set_i = pa[7:5];
  assign wrd = pa[4:2];
  assign tag = pa[31:8];
  assign wb_tlp = wb_tl - PW'(1);

  // ****************************************
  // lookups
  // ****************************************
  // tag match over all ways of the block
  always_comb begin
    m_hit = 1'b0;
    m_way = '0;
    n_hit = 1'b0;
    n_way = 1'b0;
    r_hit = 1'b0;
    r_ent = '0;
    for (int w = 0; w < dcb_pkg::M_WAYS; w++) begin
      if (m_val[{w[4:0], set_i}] && m_tag[{w[4:0], set_i}] == tag) begin
        m_hit = 1'b1;
        m_way = w[4:0];
      end
    end
    for (int w = 0; w < dcb_pkg::N_WAYS; w++) begin
      if (n_val[{w[0], set_i}] && n_tag[{w[0], set_i}] == tag) begin
        n_hit = 1'b1;
        n_way = w[0];
      end
    end
    // any entry holding this word may answer
    for (int e = 0; e < dcb_pkg::PB_ENTRIES; e++) begin
      if (pb_line[e] == pa[31:5] && pb_vld[e][wrd]) begin
        r_hit = 1'b1;
        r_ent = e[1:0];
      end
    end
  end

  // ****************************************
  // core request decision
  // ****************************************
  logic serve, ld, abt, rbh, chit, unch, wmerge, wbuf, mrg_hit;
  logic can_enq, miss_go, drain_go, rb_go, enq_new, merge_w, pop;
  logic [31:0] rd_mux;

  assign ld = !core_req.we;
  assign serve = (st == dcb_pkg::S_IDLE || st == dcb_pkg::S_RBF) &&
                 core_req.valid && !sync_pend;
  assign abt = tlb_fault || pa[31:28] == dcb_pkg::RESV_NIB;
  assign rbh = r_hit && tlb_hit;
  assign chit = m_hit || n_hit;
  assign unch = unc_vld && unc_addr == pa[31:2];
  assign wmerge = !core_req.bufferable && core_req.cacheable &&
                  core_req.multiple;
  assign wbuf = ctrl[dcb_pkg::CTRL_WBEN] &&
                (core_req.bufferable || wmerge);
  // only merging entries accept further words
  assign mrg_hit = wbuf && wmerge && wb_cnt != '0 && wb_mrg[wb_tlp] &&
                   wb_line[wb_tlp] == pa[31:5] &&
                   !(st == dcb_pkg::S_DRAIN && wb_tlp == wb_hd &&
                     wrd <= cnt);
  assign can_enq = wb_cnt != CW'(WB_DEPTH);
  always_comb begin
    core_ready = 1'b0;
    if (serve) begin
      if (abt) begin
        core_ready = 1'b1;
      end else if (ld) begin
        core_ready = rbh || chit || unch;
      end else begin
        core_ready = chit || mrg_hit || can_enq;
      end
    end
  end
  assign miss_go = st == dcb_pkg::S_IDLE && core_req.valid && !sync_pend &&
                   !abt && ld && !(rbh || chit || unch) && wb_cnt == '0;
  assign drain_go = st == dcb_pkg::S_IDLE && !miss_go && wb_cnt != '0;
  assign rb_go = st == dcb_pkg::S_IDLE && !miss_go && wb_cnt == '0 &&
                 pb_pend;
  assign enq_new = core_ready && !ld && !abt && !chit && !mrg_hit;
  assign merge_w = core_ready && !ld && !abt && !chit && mrg_hit;
  assign pop = st == dcb_pkg::S_DRAIN && cnt == 3'h7 &&
               (!wb_msk[wb_hd][7] || mem_ack);
  // read buffer first, then the caches
  always_comb begin
    if (rbh) begin
      rd_mux = pb_dat[r_ent][wrd];
    end else if (m_hit) begin
      rd_mux = m_dat[{m_way, set_i}][wrd];
    end else if (n_hit) begin
      rd_mux = n_dat[{n_way, set_i}][wrd];
    end else begin
      rd_mux = unc_data;
    end
  end

  // registered answer to the core
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_done <= 1'b0;
      core_abort <= 1'b0;
      core_rdata <= 32'h0;
    end else begin
      core_done <= core_ready;
      core_abort <= core_ready && abt;
      if (core_ready && ld) begin
        core_rdata <= rd_mux;
      end
    end
  end

  // uncached word and unbuffered store hold
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unc_vld <= 1'b0;
      unc_addr <= '0;
      unc_data <= 32'h0;
      sync_pend <= 1'b0;
    end else begin
      if (st == dcb_pkg::S_UNC && mem_ack) begin
        unc_vld <= 1'b1;
        unc_addr <= {vline, cnt};
        unc_data <= mem_rdata;
      end else if (core_ready && ld && !rbh && !chit) begin
        unc_vld <= 1'b0;
      end
      if (enq_new && !wbuf) begin
        sync_pend <= 1'b1;
      end else if (wb_cnt == '0) begin
        sync_pend <= 1'b0;
      end
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  // victim choice, write-back, fill, drain, preload
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= dcb_pkg::S_IDLE;
      cnt <= 3'h0;
      vmini <= 1'b0;
      vidx <= 8'h0;
      vline <= '0;
      wtag <= '0;
    end else begin
      case (st)
        dcb_pkg::S_IDLE: begin
          if (miss_go) begin
            vline <= pa[31:5];
            if (core_req.bufferable && core_req.cacheable) begin
              cnt <= 3'h0;
              vmini <= core_req.mini;
              if (core_req.mini) begin
                vidx <= {4'h0, lru[set_i], set_i};
                wtag <= n_tag[{lru[set_i], set_i}];
                st <= (n_val[{lru[set_i], set_i}] &&
                       n_dty[{lru[set_i], set_i}]) ?
                      dcb_pkg::S_WBACK : dcb_pkg::S_FILL;
              end else begin
                vidx <= {rr[set_i], set_i};
                wtag <= m_tag[{rr[set_i], set_i}];
                st <= (m_val[{rr[set_i], set_i}] &&
                       m_dty[{rr[set_i], set_i}]) ?
                      dcb_pkg::S_WBACK : dcb_pkg::S_FILL;
              end
            end else begin
              cnt <= wrd;
              st <= dcb_pkg::S_UNC;
            end
          end else if (drain_go) begin
            cnt <= 3'h0;
            st <= dcb_pkg::S_DRAIN;
          end else if (rb_go) begin
            cnt <= pb_pa[4:2];
            st <= dcb_pkg::S_RBF;
          end
        end
        dcb_pkg::S_WBACK: begin
          if (mem_ack) begin
            cnt <= cnt + 3'h1;
            if (cnt == 3'h7) begin
              st <= dcb_pkg::S_FILL;
            end
          end
        end
        dcb_pkg::S_FILL: begin
          if (mem_ack) begin
            cnt <= cnt + 3'h1;
            if (cnt == 3'h7) begin
              st <= dcb_pkg::S_IDLE;
            end
          end
        end
        dcb_pkg::S_UNC: begin
          if (mem_ack) begin
            st <= dcb_pkg::S_IDLE;
          end
        end
        dcb_pkg::S_DRAIN: begin
          if (!wb_msk[wb_hd][cnt] || mem_ack) begin
            cnt <= cnt + 3'h1;
            if (cnt == 3'h7) begin
              st <= dcb_pkg::S_IDLE;
            end
          end
        end
        dcb_pkg::S_RBF: begin
          if (mem_ack) begin
            cnt <= cnt + 3'h1;
            if (cnt == 3'h7 || pb_left == 4'h1) begin
              st <= dcb_pkg::S_IDLE;
            end
          end
        end
        default: begin
          st <= dcb_pkg::S_IDLE;
        end
      endcase
    end
  end

  // memory request from the sequencer state
  always_comb begin
    mem_req = '0;
    case (st)
      dcb_pkg::S_WBACK: begin
        mem_req.valid = 1'b1;
        mem_req.we = 1'b1;
        mem_req.burst = 1'b1;
        mem_req.addr = {wtag, vidx[2:0], cnt, 2'h0};
        mem_req.wdata = vmini ? n_dat[vidx[3:0]][cnt] : m_dat[vidx][cnt];
      end
      dcb_pkg::S_FILL: begin
        mem_req.valid = 1'b1;
        mem_req.burst = 1'b1;
        mem_req.addr = {vline, cnt, 2'h0};
      end
      dcb_pkg::S_UNC: begin
        mem_req.valid = 1'b1;
        mem_req.addr = {vline, cnt, 2'h0};
      end
      dcb_pkg::S_DRAIN: begin
        mem_req.valid = wb_msk[wb_hd][cnt];
        mem_req.we = 1'b1;
        mem_req.burst = wb_mrg[wb_hd];
        mem_req.addr = {wb_line[wb_hd], cnt, 2'h0};
        mem_req.wdata = wb_dat[wb_hd][cnt];
      end
      dcb_pkg::S_RBF: begin
        mem_req.valid = 1'b1;
        mem_req.burst = 1'b1;
        mem_req.addr = {pb_line[pb_e], cnt, 2'h0};
      end
      default: begin
        mem_req = '0;
      end
    endcase
  end

  // ****************************************
  // cache arrays
  // ****************************************
  // line data and tags, store hits and fills
  always_ff @(posedge hclk) begin
    if (core_ready && !ld && !abt && chit) begin
      if (m_hit) begin
        m_dat[{m_way, set_i}][wrd] <= core_req.wdata;
      end else begin
        n_dat[{n_way, set_i}][wrd] <= core_req.wdata;
      end
    end
    if (st == dcb_pkg::S_FILL && mem_ack) begin
      if (vmini) begin
        n_dat[vidx[3:0]][cnt] <= mem_rdata;
        n_tag[vidx[3:0]] <= vline[26:3];
      end else begin
        m_dat[vidx][cnt] <= mem_rdata;
        m_tag[vidx] <= vline[26:3];
      end
    end
  end

  // valid, dirty and replacement state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      m_val <= '0;
      m_dty <= '0;
      n_val <= '0;
      n_dty <= '0;
      lru <= 8'h0;
      for (int s = 0; s < 8; s++) begin
        rr[s] <= 5'h0;
      end
    end else begin
      if (core_ready && !abt && n_hit && !m_hit && !(ld && rbh)) begin
        lru[set_i] <= !n_way;
      end
      if (core_ready && !ld && !abt && chit) begin
        if (m_hit) begin
          m_dty[{m_way, set_i}] <= 1'b1;
        end else begin
          n_dty[{n_way, set_i}] <= 1'b1;
        end
      end
      if (st == dcb_pkg::S_FILL && mem_ack && cnt == 3'h7) begin
        if (vmini) begin
          n_val[vidx[3:0]] <= 1'b1;
          n_dty[vidx[3:0]] <= 1'b0;
          lru[vidx[2:0]] <= !vidx[3];
        end else begin
          m_val[vidx] <= 1'b1;
          m_dty[vidx] <= 1'b0;
          rr[vidx[2:0]] <= rr[vidx[2:0]] + 5'h1;
        end
      end
    end
  end

  // ****************************************
  // write buffer
  // ****************************************
  // entry contents, new entry or merged word
  always_ff @(posedge hclk) begin
    if (enq_new) begin
      wb_line[wb_tl] <= pa[31:5];
      wb_msk[wb_tl] <= 8'h01 << wrd;
      wb_dat[wb_tl][wrd] <= core_req.wdata;
      wb_mrg[wb_tl] <= wbuf && wmerge;
    end
    if (merge_w) begin
      wb_msk[wb_tlp] <= wb_msk[wb_tlp] | (8'h01 << wrd);
      wb_dat[wb_tlp][wrd] <= core_req.wdata;
    end
  end

  // pointers and fill level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wb_hd <= '0;
      wb_tl <= '0;
      wb_cnt <= '0;
    end else begin
      if (enq_new) begin
        wb_tl <= wb_tl + PW'(1);
      end
      if (pop) begin
        wb_hd <= wb_hd + PW'(1);
      end
      if (enq_new && !pop) begin
        wb_cnt <= wb_cnt + CW'(1);
      end else if (pop && !enq_new) begin
        wb_cnt <= wb_cnt - CW'(1);
      end
    end
  end

  // flush request from the core
  assign flush_ready = flush_valid &&
                       ((flush_user && ctrl[dcb_pkg::CTRL_URB]) ||
                        (wb_cnt == '0 && st != dcb_pkg::S_DRAIN));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      undef_exc <= 1'b0;
    end else begin
      undef_exc <= flush_valid && flush_user &&
                   ctrl[dcb_pkg::CTRL_URB];
    end
  end

  // ****************************************
  // read buffer
  // ****************************************
  // reload only on a software command
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int e = 0; e < dcb_pkg::PB_ENTRIES; e++) begin
        pb_line[e] <= '0;
        pb_vld[e] <= 8'h0;
      end
    end else if (rb_go) begin
      pb_line[pb_e] <= pb_pa[31:5];
      pb_vld[pb_e] <= 8'h0;
    end else if (st == dcb_pkg::S_RBF && mem_ack) begin
      pb_vld[pb_e][cnt] <= 1'b1;
    end
  end

  // preloaded words
  always_ff @(posedge hclk) begin
    if (st == dcb_pkg::S_RBF && mem_ack) begin
      pb_dat[pb_e][cnt] <= mem_rdata;
    end
  end

  // ****************************************
  // register slave
  // ****************************************
  logic [2:0] ev;
  logic wr_go;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wr_go = a_sel && a_we;
  assign ev = {st == dcb_pkg::S_RBF && mem_ack &&
               (cnt == 3'h7 || pb_left == 4'h1),
               flush_valid && flush_user && ctrl[dcb_pkg::CTRL_URB],
               core_ready && abt};
  assign irq = |(stat & mask);

  // address phase capture and read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_sel <= 1'b0;
      a_we <= 1'b0;
      a_off <= 8'h0;
      hrdata <= 32'h0;
    end else if (hready) begin
      a_sel <= hsel && htrans[1];
      a_we <= hwrite;
      a_off <= haddr[7:0];
      if (hsel && htrans[1] && !hwrite) begin
        case (haddr[7:0])
          dcb_pkg::OFF_CTRL: hrdata <= {30'h0, ctrl};
          dcb_pkg::OFF_STAT: hrdata <= {29'h0, stat};
          dcb_pkg::OFF_MASK: hrdata <= {29'h0, mask};
          dcb_pkg::OFF_PBADDR: hrdata <= pb_addr;
          dcb_pkg::OFF_INFO: begin
            hrdata <= (32'(pb_pend || st == dcb_pkg::S_RBF)
                       << dcb_pkg::INFO_PB) |
                      (32'(st) << dcb_pkg::INFO_ST) | 32'(wb_cnt);
          end
          default: hrdata <= 32'h0;
        endcase
      end
    end
  end

  // control, status, mask and preload command
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= dcb_pkg::CTRL_RST;
      stat <= dcb_pkg::STAT_RST;
      mask <= 3'h0;
      pb_addr <= 32'h0;
      pb_pend <= 1'b0;
      pb_e <= 2'h0;
      pb_left <= 4'h0;
    end else begin
      if (wr_go && a_off == dcb_pkg::OFF_CTRL) begin
        ctrl <= hwdata[1:0];
      end
      if (wr_go && a_off == dcb_pkg::OFF_MASK) begin
        mask <= hwdata[2:0];
      end
      if (wr_go && a_off == dcb_pkg::OFF_PBADDR) begin
        pb_addr <= hwdata;
      end
      // set beats clear
      if (wr_go && a_off == dcb_pkg::OFF_STAT) begin
        stat <= (stat & ~hwdata[2:0]) | ev;
      end else begin
        stat <= stat | ev;
      end
      if (rb_go) begin
        pb_pend <= 1'b0;
      end else if (wr_go && a_off == dcb_pkg::OFF_PBCMD && !pb_pend &&
                   st != dcb_pkg::S_RBF) begin
        pb_pend <= 1'b1;
        pb_e <= hwdata[1:0];
        pb_left <= (hwdata[dcb_pkg::RBC_CNT+:4] == 4'h0) ? 4'h1 :
                   hwdata[dcb_pkg::RBC_CNT+:4];
      end
      if (st == dcb_pkg::S_RBF && mem_ack) begin
        pb_left <= pb_left - 4'h1;
      end
    end
  end
endmodule

// [dcb_mem_model.sv]
// external memory model answering the block's word requests
module dcb_mem_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire dcb_pkg::dcb_mem_req_t mem_req,
  input wire logic slow,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [1:0] cnt;
  // read data echoes the address seen; between words it toggles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_ack <= 1'b0;
      cnt <= 2'h0;
      mem_rdata <= 32'h0;
    end else if (mem_req.valid && !mem_ack && (!slow || cnt == 2'h3)) begin
      mem_ack <= 1'b1;
      cnt <= 2'h0;
      mem_rdata <= mem_req.addr;
    end else begin
      mem_ack <= 1'b0;
      cnt <= mem_req.valid ? cnt + 2'h1 : 2'h0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// [dcb_pkg.sv]
// package: constants and types for the data cache block
package dcb_pkg;
  localparam int LINE_WORDS = 8;
  localparam int M_WAYS = 32;
  localparam int N_WAYS = 2;
  localparam int PB_ENTRIES = 4;
  localparam int ALIAS_BIT = 26;
  localparam logic [1:0] STATIC_TOP = 2'h0;
  localparam logic [3:0] RESV_NIB = 4'hb;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_MASK = 8'h08;
  localparam logic [7:0] OFF_PBADDR = 8'h0c;
  localparam logic [7:0] OFF_PBCMD = 8'h10;
  localparam logic [7:0] OFF_INFO = 8'h14;
  localparam int CTRL_WBEN = 0;
  localparam int CTRL_URB = 1;
  localparam int ST_ABT = 0;
  localparam int ST_UND = 1;
  localparam int ST_RBD = 2;
  localparam int RBC_CNT = 2;
  localparam int INFO_ST = 4;
  localparam int INFO_PB = 8;
  localparam logic [1:0] CTRL_RST = 2'h1;
  localparam logic [2:0] STAT_RST = 3'h0;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_WBACK = 3'h1,
    S_FILL = 3'h3,
    S_UNC = 3'h2,
    S_DRAIN = 3'h6,
    S_RBF = 3'h4
  } dcb_state_t;

  typedef struct packed {
    logic valid;
    logic we;
    logic multiple;
    logic bufferable;
    logic cacheable;
    logic mini;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dcb_core_req_t;

  typedef struct packed {
    logic valid;
    logic we;
    logic burst;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dcb_mem_req_t;
endpackage

// [tb.sv]
// self-checking bench for the data cache block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic tlb_hit = 1'b0;
  logic tlb_fault = 1'b0;
  logic flush_valid = 1'b0;
  logic flush_user = 1'b0;
  logic slow = 1'b0;
  dcb_pkg::dcb_core_req_t core_req = '0;
  dcb_pkg::dcb_mem_req_t mem_req;
  logic hreadyout, hresp, core_ready, core_done, core_abort;
  logic flush_ready, undef_exc, mem_ack, irq, ab, lb;
  logic [31:0] hrdata, core_rdata, mem_rdata, r, fwa, lwa;
  int n_mismatch = 0;
  int tests_run = 0;
  int n_rd = 0;
  int n_wr = 0;
  int waited, i;
  always #2.5 hclk = ~hclk;
  dcb_data_cache uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .core_req(core_req), .core_ready(core_ready),
    .core_done(core_done), .core_abort(core_abort),
    .core_rdata(core_rdata), .tlb_hit(tlb_hit), .tlb_fault(tlb_fault),
    .flush_valid(flush_valid), .flush_user(flush_user),
    .flush_ready(flush_ready), .undef_exc(undef_exc), .mem_req(mem_req),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .irq(irq)
  );
  dcb_mem_model u_mem (
    .hclk(hclk), .hresetn(hresetn), .mem_req(mem_req), .slow(slow),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata)
  );
  // count memory words as they are taken
  always @(posedge hclk) begin
    if (mem_req.valid && mem_ack) begin
      if (mem_req.we) begin
        if (n_wr == 0) fwa = mem_req.addr;
        n_wr++;
        lwa = mem_req.addr;
        lb = mem_req.burst;
      end else n_rd++;
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  // single word bus cycle; read data lands in r
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    #1;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(r, e);
  endtask
  // flags: we, multiple, bufferable, cacheable, mini
  task core_op(input logic [4:0] f, input logic [31:0] a, d);
    waited = 0;
    @(posedge hclk);
    core_req <= {1'b1, f, a, d};
    do begin
      @(posedge hclk);
      waited++;
    end while (core_ready !== 1'b1 && waited < 2000);
    core_req <= '0;
    #1;
    chk(core_done, 1'b1);
    r = core_rdata;
    ab = core_abort;
  endtask
  task flush(input logic u, input logic x);
    waited = 0;
    @(posedge hclk);
    flush_valid <= 1'b1;
    flush_user <= u;
    do begin
      @(posedge hclk);
      waited++;
    end while (flush_ready !== 1'b1 && waited < 2000);
    flush_valid <= 1'b0;
    #1;
    chk(undef_exc, x);
  endtask
  task t_regs;
    rchk(dcb_pkg::OFF_CTRL, {30'h0, dcb_pkg::CTRL_RST});
    rchk(dcb_pkg::OFF_STAT, 32'h0);
    ahb(1'b1, dcb_pkg::OFF_MASK, 32'h0);
    rchk(8'h20, 32'h0);
    $display("regs done");
  endtask
  task t_abort;
    core_op(5'h00, 32'hb000_0000, 32'h0);
    chk(ab, 1'b1);
    rchk(dcb_pkg::OFF_STAT, 32'h1);
    chk(irq, 1'b0);
    ahb(1'b1, dcb_pkg::OFF_MASK, 32'h1);
    chk(irq, 1'b1);
    ahb(1'b1, dcb_pkg::OFF_STAT, 32'h1);
    chk(irq, 1'b0);
    tlb_fault = 1'b1;
    core_op(5'h00, 32'h0000_0040, 32'h0);
    tlb_fault = 1'b0;
    chk(ab, 1'b1);
    ahb(1'b1, dcb_pkg::OFF_STAT, 32'h1);
    $display("abort done");
  endtask
  task t_alias;
    core_op(5'h00, 32'h0400_0010, 32'h0);
    chk(r, 32'h0000_0010);
    $display("alias done");
  endtask
  task t_evict;
    core_op(5'h06, 32'h0010_0000, 32'h0);
    chk(r, 32'h0010_0000);
    n_rd = 0;
    core_op(5'h06, 32'h0010_0004, 32'h0);
    chk(r, 32'h0010_0004);
    core_op(5'h16, 32'h0010_0008, 32'h1234_5678);
    chk(n_rd, 0);
    n_wr = 0;
    for (i = 1; i <= 32; i++) core_op(5'h06, 32'h0010_0000 + i * 256, 0);
    chk(n_wr, 8);
    chk(fwa, 32'h0010_0000);
    $display("evict done");
  endtask
  // mini cache refill picks the least recently used way of the set
  task t_mini;
    core_op(5'h07, 32'h0050_0020, 32'h0);
    core_op(5'h07, 32'h0050_0120, 32'h0);
    core_op(5'h07, 32'h0050_0020, 32'h0);
    core_op(5'h07, 32'h0050_0220, 32'h0);
    n_rd = 0;
    core_op(5'h07, 32'h0050_0020, 32'h0);
    chk(n_rd, 0);
    chk(r, 32'h0050_0020);
    $display("mini done");
  endtask
  task t_wbuf;
    slow = 1'b1;
    n_wr = 0;
    core_op(5'h14, 32'h0030_0000, 32'hcafe_0001);
    chk(waited, 1);
    chk(n_wr, 0);
    flush(1'b0, 1'b0);
    chk(lwa, 32'h0030_0000);
    slow = 1'b0;
    for (i = 0; i < 2; i++) begin
      n_wr = 0;
      core_op(i ? 5'h1a : 5'h1c, 32'h0040_0000, 32'h1);
      core_op(i ? 5'h1a : 5'h1c, 32'h0040_0004, 32'h2);
      flush(1'b0, 1'b0);
      chk(n_wr, 2);
      chk(lb, i);
    end
    $display("write buffer done");
  endtask
  task t_flush;
    ahb(1'b1, dcb_pkg::OFF_CTRL, 32'h3);
    flush(1'b1, 1'b1);
    rchk(dcb_pkg::OFF_STAT, 32'h2);
    ahb(1'b1, dcb_pkg::OFF_STAT, 32'h2);
    ahb(1'b1, dcb_pkg::OFF_CTRL, 32'h1);
    $display("flush done");
  endtask
  task t_rbuf;
    flush(1'b0, 1'b0);
    ahb(1'b1, dcb_pkg::OFF_PBADDR, 32'h0020_0000);
    ahb(1'b1, dcb_pkg::OFF_PBCMD, 32'h21);
    i = 0;
    do begin
      ahb(1'b0, dcb_pkg::OFF_INFO, 32'h0);
      i++;
    end while (r[8] !== 1'b0 && i < 100);
    rchk(dcb_pkg::OFF_STAT, 32'h4);
    tlb_hit = 1'b1;
    n_rd = 0;
    core_op(5'h06, 32'h0020_0014, 32'h0);
    chk(r, 32'h0020_0014);
    chk(waited, 1);
    chk(n_rd, 0);
    tlb_hit = 1'b0;
    n_rd = 0;
    core_op(5'h00, 32'h0020_0018, 32'h0);
    chk(n_rd, 1);
    $display("read buffer done");
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // main sequence after six reset cycles
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_abort;
    t_alias;
    t_evict;
    t_mini;
    t_wbuf;
    t_flush;
    t_rbuf;
    wrap_up;
  end
  // watchdog against a hang
  initial begin
    #200000;
    n_mismatch++;
    wrap_up;
  end
endmodule
